// ### src/resync_sel_regs.vh
`ifndef RESYNC_SEL_REGS_VH
`define RESYNC_SEL_REGS_VH

// resync fixed part, 20 channel bits, sent msb first
`define RS_LEN 20
// fixed part as the encoder would produce it from the assumed bits
`define RS_ENCODED 20'h11102
// single channel bit inverted after encoding
`define RS_INV_MASK 20'h01000
// position of the x edge bit inside the fixed part
`define RS_X_POS 18

// selectable tail: three leading bits, then the y edge bit
`define TAIL_LEN 4
`define TAIL_PLAIN 3'h0
`define TAIL_FLIPPED 3'h4

// resync steps per sector
`define RESYNC_STEPS 39

// running sum value at sector start
`define DSV_CLEAR 16'h0000

`endif

// ### src/blk_fifo.v
`timescale 1ns/100ps

module blk_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

localparam [AW:0] DEPTH_C = DEPTH;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [AW:0] cnt_r;
reg full_r;
reg out_valid_r;
reg [WIDTH-1:0] out_data_r;

// a push while full is refused even if a pop frees a slot this cycle
wire push = in_valid_i && !full_r;
wire pop = (cnt_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready_i);
wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

always @(posedge mclk_i) begin
    if (push) begin
        mem[wp_r] <= in_data_i;
    end
end

always @(posedge mclk_i) begin
    if (!reset_n_i) begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
        full_r <= 1'b0;
        out_valid_r <= 1'b0;
        out_data_r <= {WIDTH{1'b0}};
    end else begin
        cnt_r <= cnt_nxt;
        full_r <= (cnt_nxt == DEPTH_C);
        if (push) begin
            wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
            out_data_r <= mem[rp_r];
            rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            out_valid_r <= 1'b1;
        end else if (out_ready_i) begin
            out_valid_r <= 1'b0;
        end
    end
end

assign in_ready_o = !full_r;
assign out_valid_o = out_valid_r;
assign out_data_o = out_data_r;

endmodule // blk_fifo

// ### src/resync_dc_selector.v
// Operation
// - resync carries seven ZEROs, a ONE, six ZEROs; never made by the code
// - each resync area takes the room of exactly two data bytes
// - emit one of two resync candidates, the one minimising d.c. drift
// - irregular run found by leading edges alone or trailing edges alone
// - the two candidates differ in parity of their ONE count
// - last two data bits before resync encoded assuming ZERO ZERO follow
// - one channel bit inverted after encoding to form the irregular run
// - last three bits from prev ZERO, info ZERO ONE and next block's bit
// - choice uses surrounding data bits including edge bits x and y
// - level form toggles at each ONE and holds at each ZERO
// - running sum counts ZERO level as -1 and ONE level as +1
// - resync area is fixed part 0x010000000100000010 then selectable tail
// - selectable tail is 000y or 100y, y taken from the following data
// - each sum term starts from the final level already emitted
// - per step add tail, block, next fixed part (no fixed part on the last step); keep smaller magnitude
// - on equal magnitudes the plain tail variant is taken
`timescale 1ns/100ps
`include "resync_sel_regs.vh"

module resync_dc_selector #(
    parameter BLK_BITS = 612,
    parameter DSV_W = 16,
    parameter STEPS = `RESYNC_STEPS,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // sector control
    input wire sector_start_i,
    output wire sector_done_o,
    // coded data blocks from the encoder
    input wire blk_valid_i,
    output wire blk_ready_o,
    input wire [BLK_BITS-1:0] blk_bits_i,
    input wire blk_tail_x_i,
    input wire blk_first_info_i,
    // channel bit stream to the serialiser
    output wire ser_bit_o,
    output wire ser_valid_o,
    input wire ser_ready_i,
    // status
    output wire tail_sel_o,
    output wire [DSV_W-1:0] dsv_o
);

localparam CNT_W = 12;
localparam REST_W = BLK_BITS + `RS_LEN;
localparam WORD_W = BLK_BITS + 2;
localparam [CNT_W-1:0] BLK_CNT = BLK_BITS;
localparam [CNT_W-1:0] REST_CNT = REST_W;
localparam [CNT_W-1:0] RS_CNT = `RS_LEN;
localparam [CNT_W-1:0] TAIL_CNT = `TAIL_LEN;
localparam [5:0] LAST_STEP = STEPS;

localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_EVAL = 6'h02;
localparam [5:0] ST_TAIL = 6'h04;
localparam [5:0] ST_BLK = 6'h08;
localparam [5:0] ST_RS = 6'h10;
localparam [5:0] ST_DONE = 6'h20;

// level-form weight of one bit
function [DSV_W-1:0] unit;
    input lvl;
    begin
        unit = lvl ? {{(DSV_W-1){1'b0}}, 1'b1} : {DSV_W{1'b1}};
    end
endfunction

// sum of a four-bit tail starting from a given level
function [DSV_W-1:0] tail_dsv;
    input lvl;
    input [3:0] pat;
    reg l;
    integer i;
    begin
        l = lvl;
        tail_dsv = {DSV_W{1'b0}};
        for (i = 3; i >= 0; i = i - 1) begin
            l = l ^ pat[i];
            tail_dsv = tail_dsv + unit(l);
        end
    end
endfunction

function [DSV_W-1:0] mag;
    input [DSV_W-1:0] v;
    begin
        mag = v[DSV_W-1] ? (~v + {{(DSV_W-1){1'b0}}, 1'b1}) : v;
    end
endfunction

// fixed part with the x edge bit filled in
function [`RS_LEN-1:0] rs_word;
    input x;
    begin
        rs_word = `RS_ENCODED ^ `RS_INV_MASK;
        rs_word[`RS_X_POS] = x;
    end
endfunction

wire head_valid;
wire [WORD_W-1:0] head_data;
wire head_pop;

reg [5:0] state_r;
reg [5:0] step_r;
reg lvl_r;
reg [DSV_W-1:0] dsv_r;
reg [BLK_BITS-1:0] blk_r;
reg blk_x_r;
reg y_r;
reg [REST_W-1:0] rest_r;
reg ev_lvl_r;
reg [DSV_W-1:0] ev_sum_r;
reg [CNT_W-1:0] ev_cnt_r;
reg [BLK_BITS-1:0] emit_sh_r;
reg [CNT_W-1:0] emit_cnt_r;
reg ser_bit_r;
reg ser_valid_r;
reg tail_sel_r;
reg done_r;

reg [DSV_W-1:0] cand_plain;
reg [DSV_W-1:0] cand_flip;
reg pick_flip;

wire [BLK_BITS-1:0] head_bits = head_data[WORD_W-1:2];
// encoder closes each block as if ZERO ZERO followed, handing us x
wire head_x = head_data[1];
// y from prev ZERO, info ZERO ONE, then first info bit of next block
wire head_y = ~head_data[0];
wire last_step = (step_r == LAST_STEP);
wire load_ok = !ser_valid_r || ser_ready_i;
wire emitting = (state_r == ST_TAIL || state_r == ST_BLK ||
    state_r == ST_RS) && (emit_cnt_r != {CNT_W{1'b0}});
wire emit_bit = emit_sh_r[BLK_BITS-1];
wire emit_lvl = lvl_r ^ emit_bit;
wire ev_bit = rest_r[REST_W-1];
wire ev_lvl = ev_lvl_r ^ ev_bit;

assign head_pop = (state_r == ST_IDLE) && head_valid && !sector_start_i;

blk_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_fifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(blk_valid_i),
    .in_ready_o(blk_ready_o),
    .in_data_i({blk_bits_i, blk_tail_x_i, blk_first_info_i}),
    .out_valid_o(head_valid),
    .out_ready_i(head_pop),
    .out_data_o(head_data)
);

// flipped tail adds one ONE, so the rest runs at inverted level: sum negates
always @* begin
    cand_plain = dsv_r + tail_dsv(lvl_r, {`TAIL_PLAIN, y_r}) +
        ev_sum_r;
    cand_flip = dsv_r + tail_dsv(lvl_r, {`TAIL_FLIPPED, y_r}) -
        ev_sum_r;
    pick_flip = mag(cand_flip) < mag(cand_plain);
end

always @(posedge mclk_i) begin
    if (!reset_n_i) begin
        state_r <= ST_IDLE;
        step_r <= 6'h00;
        lvl_r <= 1'b0;
        dsv_r <= `DSV_CLEAR;
        blk_r <= {BLK_BITS{1'b0}};
        blk_x_r <= 1'b0;
        y_r <= 1'b0;
        rest_r <= {REST_W{1'b0}};
        ev_lvl_r <= 1'b0;
        ev_sum_r <= {DSV_W{1'b0}};
        ev_cnt_r <= {CNT_W{1'b0}};
        emit_sh_r <= {BLK_BITS{1'b0}};
        emit_cnt_r <= {CNT_W{1'b0}};
        ser_bit_r <= 1'b0;
        ser_valid_r <= 1'b0;
        tail_sel_r <= 1'b0;
        done_r <= 1'b0;
    end else if (sector_start_i) begin
        state_r <= ST_IDLE;
        step_r <= 6'h00;
        lvl_r <= 1'b0;
        dsv_r <= `DSV_CLEAR;
        emit_cnt_r <= {CNT_W{1'b0}};
        ser_valid_r <= 1'b0;
        done_r <= 1'b0;
    end else begin
        // output stage: one channel bit per accepted transfer
        if (emitting && load_ok) begin
            ser_bit_r <= emit_bit;
            ser_valid_r <= 1'b1;
            emit_sh_r <= {emit_sh_r[BLK_BITS-2:0], 1'b0};
            emit_cnt_r <= emit_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            lvl_r <= emit_lvl;
            dsv_r <= dsv_r + unit(emit_lvl);
        end else if (ser_ready_i) begin
            ser_valid_r <= 1'b0;
        end

        case (state_r)
            ST_IDLE: begin
                if (head_pop) begin
                    blk_x_r <= head_x;
                    if (step_r == 6'h00) begin
                        // first block goes out with no resync before it
                        emit_sh_r <= head_bits;
                        emit_cnt_r <= BLK_CNT;
                        state_r <= ST_BLK;
                    end else begin
                        blk_r <= head_bits;
                        y_r <= head_y;
                        rest_r <= {head_bits, rs_word(head_x)};
                        // plain tail ends at the emitted level xor y
                        ev_lvl_r <= lvl_r ^ head_y;
                        ev_sum_r <= {DSV_W{1'b0}};
                        ev_cnt_r <= last_step ? BLK_CNT : REST_CNT;
                        state_r <= ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                if (ev_cnt_r != {CNT_W{1'b0}}) begin
                    rest_r <= {rest_r[REST_W-2:0], 1'b0};
                    ev_lvl_r <= ev_lvl;
                    ev_sum_r <= ev_sum_r + unit(ev_lvl);
                    ev_cnt_r <= ev_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
                end else begin
                    tail_sel_r <= pick_flip;
                    emit_sh_r <= {pick_flip ? `TAIL_FLIPPED : `TAIL_PLAIN,
                        y_r, {(BLK_BITS-4){1'b0}}};
                    emit_cnt_r <= TAIL_CNT;
                    state_r <= ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (emit_cnt_r == {CNT_W{1'b0}}) begin
                    emit_sh_r <= blk_r;
                    emit_cnt_r <= BLK_CNT;
                    state_r <= ST_BLK;
                end
            end
            ST_BLK: begin
                if (emit_cnt_r == {CNT_W{1'b0}}) begin
                    if (last_step) begin
                        done_r <= 1'b1;
                        state_r <= ST_DONE;
                    end else begin
                        emit_sh_r <= {rs_word(blk_x_r),
                            {(BLK_BITS-`RS_LEN){1'b0}}};
                        emit_cnt_r <= RS_CNT;
                        state_r <= ST_RS;
                    end
                end
            end
            ST_RS: begin
                if (emit_cnt_r == {CNT_W{1'b0}}) begin
                    step_r <= step_r + 6'h01;
                    state_r <= ST_IDLE;
                end
            end
            ST_DONE: begin
                state_r <= ST_DONE;
            end
            default: begin
                state_r <= ST_IDLE;
            end
        endcase
    end
end

assign sector_done_o = done_r;
assign ser_bit_o = ser_bit_r;
assign ser_valid_o = ser_valid_r;
assign tail_sel_o = tail_sel_r;
assign dsv_o = dsv_r;

endmodule // resync_dc_selector

// ### verification/resync_sel_chk_sva.sv
`timescale 1ns/100ps
module resync_sel_chk #(
    parameter BLK_BITS = 612,
    parameter DSV_W = 16
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // watched ports
    input wire sector_start_i,
    input wire sector_done_o,
    input wire blk_valid_i,
    input wire blk_ready_o,
    input wire ser_bit_o,
    input wire ser_valid_o,
    input wire ser_ready_i,
    input wire tail_sel_o,
    input wire [DSV_W-1:0] dsv_o
);
    localparam integer LIM = 40 * BLK_BITS + 39 * 24;
    wire signed [DSV_W-1:0] d = dsv_o;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    bit_hold_a:
    assert property (ser_valid_o && !ser_ready_i |=> ser_valid_o
        && $stable(ser_bit_o)) else $error("bit lost");
    sum_step_a:
    assert property ($changed(d) && !$past(sector_start_i)
        |-> d == $past(d) + 1 || d == $past(d) - 1) else $error("bad step");
    sum_load_a:
    assert property ($changed(d) && !$past(sector_start_i) |-> ser_valid_o)
        else $error("sum moved idle");
    sum_clear_a:
    assert property (sector_start_i |=> d == 0 && !sector_done_o)
        else $error("no clear");
    reset_out_a:
    assert property ($rose(reset_n_i)
        |-> {d, ser_valid_o, tail_sel_o, sector_done_o} == 0)
        else $error("reset values");
    done_hold_a:
    assert property (sector_done_o && !sector_start_i |=> sector_done_o)
        else $error("done dropped");
    tail_gap_a:
    assert property ($changed(tail_sel_o) |-> !$past(ser_valid_o))
        else $error("tail moved");
    sum_range_a:
    assert property (d <= LIM && d >= -LIM) else $error("sum range");
    cover property (blk_valid_i && !blk_ready_o);
    cover property ($rose(tail_sel_o));
    cover property ($rose(sector_done_o));
endmodule // resync_sel_chk

bind resync_dc_selector resync_sel_chk #(.BLK_BITS(BLK_BITS),
    .DSV_W(DSV_W)) u_chk (.mclk_i, .reset_n_i, .sector_start_i,
    .sector_done_o, .blk_valid_i, .blk_ready_o, .ser_bit_o,
    .ser_valid_o, .ser_ready_i, .tail_sel_o, .dsv_o);

// ### verification/blk_source.sv
`timescale 1ns/100ps
module blk_source #(
    parameter BW = 8
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // launch and block table
    input wire go_i,
    input wire [BW+1:0] words_i [0:39],
    // block stream
    output reg blk_valid_o = 1'b0,
    input wire blk_ready_i,
    output reg [BW+1:0] word_o = '0
);
    integer idx = 40;
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            idx <= 40;
        else if (go_i)
            idx <= 0;
        else if (blk_valid_o && blk_ready_i)
            idx <= idx + 1;
    end
    // idle lines wander so stale data is never mistaken for a word
    always @(negedge mclk_i) begin
        blk_valid_o <= idx < 40;
        if (idx < 40)
            word_o <= words_i[idx];
        else
            word_o <= ~word_o;
    end
endmodule // blk_source

// ### verification/resync_dc_selector_tb_top.sv
`timescale 1ns/100ps
module resync_dc_selector_tb_top;
    // blocks must be at least as long as the 20-bit fixed part
    localparam BW = 24;
    reg mclk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg sector_start_i = 1'b0;
    reg ser_ready_i = 1'b1;
    reg go = 1'b0;
    wire sector_done_o, blk_valid_i, blk_ready_o, ser_bit_o;
    wire ser_valid_o, tail_sel_o;
    wire [BW+1:0] word;
    wire [15:0] dsv_o;
    logic [BW+1:0] words [0:39];
    bit exp_q[$];
    bit lv;
    integer n_fail = 0, compares = 0, ds, mode = 0, rnd, coin;
    integer seed = 32'had48014b;

    always #2.5 mclk_i = ~mclk_i;

    resync_dc_selector #(.BLK_BITS(BW)) i_dut (.mclk_i, .reset_n_i,
        .sector_start_i, .sector_done_o, .blk_valid_i, .blk_ready_o,
        .blk_bits_i(word[BW+1:2]), .blk_tail_x_i(word[1]),
        .blk_first_info_i(word[0]), .ser_bit_o, .ser_valid_o,
        .ser_ready_i, .tail_sel_o, .dsv_o);
    blk_source #(.BW(BW)) i_src (.mclk_i, .reset_n_i, .go_i(go),
        .words_i(words), .blk_valid_o(blk_valid_i),
        .blk_ready_i(blk_ready_o), .word_o(word));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic void put(bit b);
        exp_q.push_back(b);
        lv ^= b;
        ds += lv ? 1 : -1;
    endfunction

    // magnitude after a candidate tail, nothing committed
    function automatic integer cost(bit [3:0] tl, bit rest[$]);
        integer d = ds;
        bit l = lv;
        for (int i = 0; i < 4 + rest.size(); i++) begin
            l ^= i < 4 ? tl[3-i] : rest[i-4];
            d += l ? 1 : -1;
        end
        return d < 0 ? -d : d;
    endfunction

    task automatic plan(input integer kind);
        bit rest[$];
        logic [19:0] r;
        bit y;
        for (int m = 0; m < 40; m++) begin
            rnd = $random(seed);
            words[m] = rnd[BW+1:0];
            if (kind > 0)
                words[m][BW+1:2] = kind == 1 ? '0 : '1;
        end
        ds = 0;
        lv = 0;
        for (int m = 0; m < 40; m++) begin
            if (m > 0) begin
                r = 20'h10102 | {1'b0, words[m-1][1], 18'h0};
                for (int i = 19; i >= 0; i--)
                    put(r[i]);
                rest = {};
                for (int i = BW + 1; i >= 2; i--)
                    rest.push_back(words[m][i]);
                r = 20'h10102 | {1'b0, words[m][1], 18'h0};
                for (int i = 19; i >= 0 && m < 39; i--)
                    rest.push_back(r[i]);
                y = !words[m][0];
                put(cost({3'h4, y}, rest) < cost({3'h0, y}, rest));
                put(0);
                put(0);
                put(y);
            end
            for (int i = BW + 1; i >= 2; i--)
                put(words[m][i]);
        end
    endtask

    task automatic run(input integer kind, input integer hold);
        integer k;
        plan(kind);
        mode = hold;
        go = 1;
        @(negedge mclk_i);
        go = 0;
        if (hold) begin
            repeat (200) @(negedge mclk_i);
            check(blk_ready_o, 0);
            mode = 2;
        end
        for (k = 0; k < 20000; k++) begin
            if (sector_done_o === 1'b1 && exp_q.size() == 0)
                break;
            @(negedge mclk_i);
        end
        check(k < 20000, 1);
        check(dsv_o, ds[15:0]);
        $display("sector kind %0d hold %0d done", kind, hold);
    endtask

    always @(negedge mclk_i) begin
        coin = $random(seed);
        ser_ready_i <= mode == 0 || (mode == 2 && coin[0]);
    end

    always @(posedge mclk_i) begin
        if (reset_n_i && ser_valid_o && ser_ready_i) begin
            if (exp_q.size() == 0)
                check(ser_bit_o, 2);
            else
                check(ser_bit_o, exp_q.pop_front());
        end
    end

    initial begin
        repeat (8) @(negedge mclk_i);
        reset_n_i = 1;
        for (int s = 0; s < 4; s++) begin
            if (s == 2) begin
                reset_n_i = 0;
                repeat (2) @(negedge mclk_i);
                reset_n_i = 1;
                check({ser_valid_o, tail_sel_o, dsv_o}, 0);
            end else if (s > 0) begin
                sector_start_i = 1;
                @(negedge mclk_i);
                sector_start_i = 0;
                check({sector_done_o, dsv_o}, 0);
            end
            run(s > 1 ? s - 1 : 0, s % 2);
        end
        wrap_up();
    end

    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
endmodule // resync_dc_selector_tb_top
